/* gpm_map.vh */
// Register offsets, codes and timing constants of the protection monitor
`ifndef GPM_MAP_VH
`define GPM_MAP_VH
// ------------------------------------------------------------
// Register offsets (holding register numbers) and stop command code
// ------------------------------------------------------------
`define GPM_REG_PASSWORD      16'h0065
`define GPM_REG_COMMAND       16'h0066
`define GPM_STOP_CODE         16'h0016
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define GPM_CLK_HZ            100000000
`define GPM_TICK_MS           1
`define GPM_TICK_CYCLES       ((`GPM_CLK_HZ / 1000) * `GPM_TICK_MS)
`define GPM_STOP_WINDOW_S     5
`define GPM_STOP_WINDOW_TICKS (`GPM_STOP_WINDOW_S * 1000 / `GPM_TICK_MS)
// ------------------------------------------------------------
// Anomaly action codes
// ------------------------------------------------------------
`define GPM_ACT_NONE          2'h0
`define GPM_ACT_PREALARM      2'h1
`define GPM_ACT_DEACT         2'h2
`define GPM_ACT_SHUTDOWN      2'h3
// ------------------------------------------------------------
// Application types, input function codes and close attempt limit
// ------------------------------------------------------------
`define GPM_APP_GENSET        2'h0
`define GPM_APP_DRIVE         2'h1
`define GPM_APP_LAMP_MAST     2'h2
`define GPM_FUNC_W            4
`define GPM_FUNC_NONE         4'h0
`define GPM_FUNC_BRK_STATUS   4'h1
`define GPM_FUNC_BRK_TRIP     4'h2
`define GPM_FUNC_OVERSPEED    4'h3
`define GPM_MAX_CLOSE_TRIES   2'h3
`endif

/* gpm_persist.v */
// Consecutive-time qualifier counting tick pulses
`timescale 1ns/1ps
module gpm_persist #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         reset_n,
	input  wire         tick,
	input  wire         enable,
	input  wire         cond,
	input  wire [W-1:0] delay,
	output reg          fire
);
	reg [W-1:0] count; // Elapsed ticks of persistence

	// ----------------------------------------------------------------
	// Counter restarts whenever the condition or enable lapses
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= {W{1'b0}};
			fire  <= 1'b0;
		end else if (!enable || !cond || delay == {W{1'b0}}) begin
			count <= {W{1'b0}}; // Restart on lapse
			fire  <= 1'b0;
		end else if (count >= delay) begin
			fire <= 1'b1; // Uninterrupted persistence reached
		end else if (tick) begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

/* gpm_remote_stop.v */
// Two-write remote stop sequence checker
`timescale 1ns/1ps
`include "gpm_map.vh"
module gpm_remote_stop (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        tick,
	input  wire        wr_en,
	input  wire [15:0] wr_addr,
	input  wire [15:0] wr_data,
	input  wire [15:0] password,
	output reg         stop_cmd
);
	localparam [31:0] WIN_W = `GPM_STOP_WINDOW_TICKS; // Window in ticks
	localparam [15:0] WIN = WIN_W[15:0]; // Sized to the timer
	reg        armed;  // Password accepted, waiting for code
	reg [15:0] timer;  // Ticks since password

	// ----------------------------------------------------------------
	// Sequence tracking
	// ----------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			armed    <= 1'b0;
			timer    <= 16'h0000;
			stop_cmd <= 1'b0;
		end else begin
			stop_cmd <= 1'b0;
			if (wr_en && wr_addr == `GPM_REG_PASSWORD) begin
				armed <= (wr_data == password);
				timer <= 16'h0000;
			end else if (wr_en && wr_addr == `GPM_REG_COMMAND) begin
				stop_cmd <= armed && wr_data == `GPM_STOP_CODE;
				armed    <= 1'b0;
			end else if (armed && tick) begin
				if (timer >= WIN - 16'h0001)
					armed <= 1'b0; // Window expired
				timer <= timer + 16'h0001;
			end
		end
	end
endmodule

/* gpm_monitor.v */
// Generator-set protection monitor top level
`timescale 1ns/1ps
`include "gpm_map.vh"
module gpm_monitor #(
	parameter DW  = 16,                 // Delay setting width
	parameter MW  = 16,                 // Measurement width
	parameter NDI = 4,                  // Digital contact inputs
	parameter TICK_CYCLES = `GPM_TICK_CYCLES, // Cycles per delay tick
	parameter OC_SCALE = 1000           // Ticks per setting unit
) (
	input  wire               clk,
	input  wire               reset_n,
	// Engine state (same clock)
	input  wire               fuel_open,
	input  wire               start_stop_phase,
	input  wire               running_detected,
	input  wire               idle_enabled,
	input  wire               idle_done,
	input  wire               in_band,
	input  wire               regen_active,
	input  wire               auto_mode,
	input  wire               manual_operation_mode,
	input  wire [1:0]         app_type,
	// Measurements (same clock)
	input  wire [MW-1:0]      gen_voltage,
	input  wire [MW-1:0]      excitation_voltage,
	input  wire [MW-1:0]      gen_current,
	// Configuration
	input  wire [MW-1:0]      hv_threshold,
	input  wire [DW-1:0]      hv_delay,
	input  wire               excitation_signal_function,
	input  wire [MW-1:0]      exc_stop_threshold,
	input  wire [DW-1:0]      exc_delay,
	input  wire [1:0]         exc_action,
	input  wire [MW-1:0]      oc_threshold,
	input  wire [DW-1:0]      oc_time,
	input  wire [MW-1:0]      sc_threshold,
	input  wire [DW-1:0]      sc_delay,
	input  wire [1:0]         max_current_action,
	input  wire [DW-1:0]      op_max_time,
	input  wire               kbd_stop_disable,
	input  wire [15:0]        password,
	input  wire               breaker_external,
	input  wire [NDI*`GPM_FUNC_W-1:0] di_function,
	input  wire [NDI*DW-1:0]  di_delay,
	// Contacts and keys (asynchronous pins)
	input  wire [NDI-1:0]     di_pin,
	input  wire               stop_key,
	// Breaker control (same clock)
	input  wire               close_cmd,
	input  wire               breaker_closed,
	// Holding register writes
	input  wire               reg_wr_en,
	input  wire [15:0]        reg_wr_addr,
	input  wire [15:0]        reg_wr_data,
	// Anomaly outputs
	output reg                overvoltage_shutdown,
	output reg  [1:0]         alternator_anomaly,
	output reg  [1:0]         overcurrent_anomaly,
	output reg  [1:0]         short_circuit_anomaly,
	output reg                manual_stop_shutdown,
	output reg                op_cond_shutdown,
	output reg                close_fail_prealarm,
	output reg                close_fail_deactivation,
	output reg                contact_short_shutdown,
	output reg                contact_overspeed_shutdown
);
	localparam FW = `GPM_FUNC_W;
	localparam [31:0] TC = TICK_CYCLES;

	// ------------------------------------------------------------
	// Timebase
	// ------------------------------------------------------------
	reg [31:0] tick_cnt; // Divider count
	reg        tick;     // One-cycle delay tick

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b0;
		end else if (tick_cnt >= TC - 32'h00000001) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 32'h00000001;
			tick     <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	reg [NDI:0] pin_meta; // First stage
	reg [NDI:0] pin_sync; // Second stage
	reg         key_prev; // Stop key edge memory

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta <= {(NDI+1){1'b0}};
			pin_sync <= {(NDI+1){1'b0}};
			key_prev <= 1'b0;
		end else begin
			pin_meta <= {stop_key, di_pin};
			pin_sync <= pin_meta;
			key_prev <= pin_sync[NDI];
		end
	end

	wire key_press = pin_sync[NDI] & ~key_prev; // Stop key rising edge

	// ------------------------------------------------------------
	// Enabling conditions
	// ------------------------------------------------------------
	wire not_drive = (app_type != `GPM_APP_DRIVE);
	wire eng_en    = fuel_open & ~start_stop_phase;
	wire gen_en    = eng_en & not_drive;
	wire exc_en    = excitation_signal_function & fuel_open;
	wire ovs_en    = eng_en & ~regen_active;
	wire op_en     = fuel_open & (auto_mode |
		(manual_operation_mode & ~not_drive));
	wire brk_allow = ~breaker_external &
		(app_type != `GPM_APP_LAMP_MAST);

	// ------------------------------------------------------------
	// Contact input decode, one generate loop pass per input
	// ------------------------------------------------------------
	wire [NDI-1:0] trip_hit;  // Trip contact qualified
	wire [NDI-1:0] ovs_hit;   // Overspeed contact qualified
	wire [NDI-1:0] brk_sel;   // Input assigned to breaker status
	wire [DW-1:0]  brk_delay_w [0:NDI-1];

	genvar gi;
	generate
		for (gi = 0; gi < NDI; gi = gi + 1) begin : g_di
			wire [FW-1:0] fn = di_function[gi*FW +: FW];
			wire [DW-1:0] dl = di_delay[gi*DW +: DW];
			assign brk_sel[gi] = (fn == `GPM_FUNC_BRK_STATUS) &&
				(dl != {DW{1'b0}});
			assign brk_delay_w[gi] = dl;
			gpm_persist #(.W(DW)) u_trip (
				.clk     (clk),
				.reset_n (reset_n),
				.tick    (tick),
				.enable  (fn == `GPM_FUNC_BRK_TRIP),
				.cond    (pin_sync[gi]),
				.delay   (dl),
				.fire    (trip_hit[gi])
			);
			gpm_persist #(.W(DW)) u_ovs (
				.clk     (clk),
				.reset_n (reset_n),
				.tick    (tick),
				.enable  (ovs_en && fn == `GPM_FUNC_OVERSPEED),
				.cond    (pin_sync[gi]),
				.delay   (dl),
				.fire    (ovs_hit[gi])
			);
		end
	endgenerate

	// Lowest assigned breaker-status input gives the delay
	reg [DW-1:0] brk_delay;
	integer      k;
	always @* begin
		brk_delay = {DW{1'b0}};
		for (k = NDI - 1; k >= 0; k = k - 1) begin
			if (brk_sel[k])
				brk_delay = brk_delay_w[k];
		end
	end
	wire brk_en = brk_allow & (|brk_sel);

	// ------------------------------------------------------------
	// Fixed-delay qualifiers on measurements
	// ------------------------------------------------------------
	wire hv_hit;  // Overvoltage qualified
	wire exc_hit; // Low excitation qualified
	wire sc_hit;  // Short circuit qualified

	gpm_persist #(.W(DW)) u_hv (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick),
		.enable  (gen_en),
		.cond    (gen_voltage > hv_threshold),
		.delay   (hv_delay),
		.fire    (hv_hit)
	);

	gpm_persist #(.W(DW)) u_exc (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick),
		.enable  (exc_en),
		.cond    (excitation_voltage < exc_stop_threshold),
		.delay   (exc_delay),
		.fire    (exc_hit)
	);

	gpm_persist #(.W(DW)) u_sc (
		.clk     (clk),
		.reset_n (reset_n),
		.tick    (tick),
		.enable  (gen_en),
		.cond    (gen_current > sc_threshold),
		.delay   (sc_delay),
		.fire    (sc_hit)
	);

	// ------------------------------------------------------------
	// Inverse-time overcurrent integral
	// Each tick above threshold adds I^2 - Ith^2; trip when sum reaches
	// Ith^2 * time * scale, giving t = T / ((I/Ith)^2 - 1)
	// ------------------------------------------------------------
	reg  [2*MW+DW+15:0] oc_acc;  // Thermal accumulator
	reg                 oc_hit;  // Integral limit reached
	wire [2*MW-1:0]     i_sq  = gen_current * gen_current;
	wire [2*MW-1:0]     th_sq = oc_threshold * oc_threshold;
	wire [2*MW+DW+15:0] oc_lim = th_sq * oc_time * OC_SCALE[15:0];
	wire                oc_over = gen_current > oc_threshold;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			oc_acc <= {(2*MW+DW+16){1'b0}};
			oc_hit <= 1'b0;
		end else if (!gen_en || oc_time == {DW{1'b0}}) begin
			oc_acc <= {(2*MW+DW+16){1'b0}};
			oc_hit <= 1'b0;
		end else begin
			if (tick && oc_over)
				oc_acc <= oc_acc + {{(DW+16){1'b0}}, i_sq - th_sq};
			if (oc_over && oc_acc >= oc_lim)
				oc_hit <= 1'b1;
			else if (!oc_over)
				oc_hit <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Operating-conditions timer
	// ------------------------------------------------------------
	reg [DW+15:0] op_cnt;   // Ticks since running or idle end
	reg           op_done;  // Conditions reached stably
	wire          op_start = running_detected &
		(~idle_enabled | idle_done);
	wire [DW+15:0] op_lim = op_max_time * OC_SCALE[15:0];

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_cnt           <= {(DW+16){1'b0}};
			op_done          <= 1'b0;
			op_cond_shutdown <= 1'b0;
		end else if (!op_en || !op_start ||
			op_max_time == {DW{1'b0}}) begin
			op_cnt  <= {(DW+16){1'b0}}; // Waits for fresh start
			op_done <= 1'b0;
		end else if (in_band) begin
			op_done <= 1'b1; // Settled in time
		end else if (!op_done) begin
			if (op_cnt >= op_lim)
				op_cond_shutdown <= 1'b1;
			else if (tick)
				op_cnt <= op_cnt + {{(DW+15){1'b0}}, 1'b1};
		end
	end

	// ------------------------------------------------------------
	// Breaker close supervision
	// ------------------------------------------------------------
	reg [DW-1:0] close_cnt;  // Ticks since close command
	reg          close_wait; // Awaiting breaker closure
	reg [1:0]    tries;      // Failed attempts in auto

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			close_cnt               <= {DW{1'b0}};
			close_wait              <= 1'b0;
			tries                   <= 2'h0;
			close_fail_prealarm     <= 1'b0;
			close_fail_deactivation <= 1'b0;
		end else if (!brk_en || breaker_closed) begin
			close_cnt  <= {DW{1'b0}};
			close_wait <= 1'b0;
			if (breaker_closed)
				tries <= 2'h0; // Success clears attempts
		end else if (close_cmd && !close_wait) begin
			close_wait <= 1'b1;
			close_cnt  <= {DW{1'b0}};
		end else if (close_wait) begin
			if (close_cnt >= brk_delay) begin
				close_wait <= 1'b0;
				if (manual_operation_mode)
					close_fail_prealarm <= 1'b1;
				else if (auto_mode) begin
					if (tries + 2'h1 >= `GPM_MAX_CLOSE_TRIES)
						close_fail_deactivation <= 1'b1;
					else
						tries <= tries + 2'h1;
				end
			end else if (tick) begin
				close_cnt <= close_cnt + {{(DW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ------------------------------------------------------------
	// Remote stop sequence
	// ------------------------------------------------------------
	wire remote_stop; // Valid two-write sequence seen

	gpm_remote_stop u_rstop (
		.clk      (clk),
		.reset_n  (reset_n),
		.tick     (tick),
		.wr_en    (reg_wr_en),
		.wr_addr  (reg_wr_addr),
		.wr_data  (reg_wr_data),
		.password (password),
		.stop_cmd (remote_stop)
	);

	// ------------------------------------------------------------
	// Anomaly latches; activation only while enabled
	// ------------------------------------------------------------
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			overvoltage_shutdown       <= 1'b0;
			alternator_anomaly         <= `GPM_ACT_NONE;
			overcurrent_anomaly        <= `GPM_ACT_NONE;
			short_circuit_anomaly      <= `GPM_ACT_NONE;
			manual_stop_shutdown       <= 1'b0;
			contact_short_shutdown     <= 1'b0;
			contact_overspeed_shutdown <= 1'b0;
		end else begin
			if (hv_hit)
				overvoltage_shutdown <= 1'b1;
			if (exc_hit)
				alternator_anomaly <= exc_action;
			if (oc_hit)
				overcurrent_anomaly <= max_current_action;
			if (sc_hit)
				short_circuit_anomaly <= max_current_action;
			if (auto_mode && !kbd_stop_disable &&
				(key_press || remote_stop))
				manual_stop_shutdown <= 1'b1;
			if (|trip_hit)
				contact_short_shutdown <= 1'b1;
			if (|ovs_hit)
				contact_overspeed_shutdown <= 1'b1;
		end
	end
endmodule

/* gpm_breaker.sv */
// Breaker model that answers close commands at the far side
`timescale 1ns/1ps
module gpm_breaker #(
	parameter LAG = 3 // Cycles from command to contact
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic close_cmd,
	input  wire logic refuse, // Jammed mechanism, never closes
	output logic      breaker_closed
);
	logic [3:0] cnt; // Travel time still to go

	// ------------------------------------------------------------
	// Mechanism travel
	// ------------------------------------------------------------
	// Closes LAG cycles after a command unless jammed
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt <= 4'h0;
			breaker_closed <= 1'b0;
		end else if (close_cmd && !refuse) begin
			cnt <= 4'(LAG);
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
			breaker_closed <= (cnt == 4'h1);
		end
	end
endmodule

/* gpm_monitor_assertions.sv */
// Port-level checks of the protection monitor
`timescale 1ns/1ps
`include "gpm_map.vh"
module gpm_monitor_assertions (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        fuel_open,
	input wire logic        start_stop_phase,
	input wire logic        auto_mode,
	input wire logic        kbd_stop_disable,
	input wire logic        regen_active,
	input wire logic        breaker_external,
	input wire logic        excitation_signal_function,
	input wire logic [1:0]  app_type,
	input wire logic [1:0]  exc_action,
	input wire logic [1:0]  max_current_action,
	input wire logic [15:0] hv_delay,
	input wire logic [15:0] password,
	input wire logic        reg_wr_en,
	input wire logic [15:0] reg_wr_addr,
	input wire logic [15:0] reg_wr_data,
	input wire logic        overvoltage_shutdown,
	input wire logic [1:0]  alternator_anomaly,
	input wire logic [1:0]  overcurrent_anomaly,
	input wire logic [1:0]  short_circuit_anomaly,
	input wire logic        manual_stop_shutdown,
	input wire logic        op_cond_shutdown,
	input wire logic        close_fail_deactivation,
	input wire logic        contact_overspeed_shutdown
);
	// ------------------------------------------------------------
	// Raise conditions of each anomaly except close fail prealarm and contact short
	// ------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	ov_gate_a: assert property (
		$rose(overvoltage_shutdown) |-> fuel_open && !start_stop_phase &&
		hv_delay != 16'h0000 && app_type != `GPM_APP_DRIVE)
		else $error("overvoltage raised while not enabled");
	alt_action_a: assert property (
		$rose(alternator_anomaly != 2'h0) |-> excitation_signal_function &&
		fuel_open && alternator_anomaly == exc_action)
		else $error("alternator anomaly gate or code wrong");
	oc_action_a: assert property (
		$rose(overcurrent_anomaly != 2'h0) |-> app_type != `GPM_APP_DRIVE
		&& overcurrent_anomaly == max_current_action)
		else $error("overcurrent anomaly code wrong");
	sc_action_a: assert property (
		$rose(short_circuit_anomaly != 2'h0) |->
		short_circuit_anomaly == max_current_action ##1
		$stable(short_circuit_anomaly) [*4])
		else $error("short circuit anomaly code wrong");
	remote_stop_a: assert property (
		reg_wr_en && reg_wr_addr == `GPM_REG_COMMAND &&
		reg_wr_data == `GPM_STOP_CODE && $past(reg_wr_en) &&
		$past(reg_wr_addr) == `GPM_REG_PASSWORD &&
		$past(reg_wr_data) == password && auto_mode && !kbd_stop_disable
		|-> ##[1:3] manual_stop_shutdown)
		else $error("remote stop not answered");
	stop_gate_a: assert property (
		$rose(manual_stop_shutdown) |-> auto_mode && !kbd_stop_disable)
		else $error("manual stop outside auto mode");
	op_gate_a: assert property (
		$rose(op_cond_shutdown) |-> fuel_open &&
		(auto_mode || app_type == `GPM_APP_DRIVE))
		else $error("operating shutdown while not enabled");
	deact_gate_a: assert property (
		$rose(close_fail_deactivation) |-> $past(auto_mode, 2) &&
		!breaker_external && app_type != `GPM_APP_LAMP_MAST)
		else $error("close deactivation while not enabled");
	overspeed_gate_a: assert property (
		$rose(contact_overspeed_shutdown) |-> !regen_active && fuel_open
		&& !start_stop_phase)
		else $error("overspeed raised while muted");
endmodule

/* gpm_monitor_bench.sv */
// Self-checking bench for the protection monitor
`timescale 1ns/1ps
`include "gpm_map.vh"
module gpm_monitor_bench;
	localparam TC = 4; // Cycles per delay tick
	localparam LIMIT = 40000; // Cycle ceiling of the run
	logic        clk = 0;
	logic        reset_n = 0;
	logic        fuel_open, start_stop_phase, running_detected, idle_enabled;
	logic        idle_done, in_band, regen_active, auto_mode, refuse;
	logic        manual_operation_mode, excitation_signal_function;
	logic        kbd_stop_disable, breaker_external, stop_key, close_cmd;
	logic        reg_wr_en;
	logic [1:0]  app_type, exc_action, max_current_action;
	logic [15:0] gen_voltage, excitation_voltage, gen_current, hv_threshold;
	logic [15:0] hv_delay, exc_stop_threshold, exc_delay, oc_threshold;
	logic [15:0] oc_time, sc_threshold, sc_delay, op_max_time, password;
	logic [15:0] reg_wr_addr, reg_wr_data, di_function;
	logic [63:0] di_delay;
	logic [3:0]  di_pin;
	wire         breaker_closed;
	wire  [12:0] outs; // All anomaly outputs packed
	logic [12:0] prev, ev; // Last seen and expected outputs
	logic [12:0] qv[$]; // Expected output notes
	int          qt[$]; // Earliest cycle of each note
	int          failures = 0, tests_run = 0, cyc = 0, i, j, seed;

	gpm_monitor #(.TICK_CYCLES(TC), .OC_SCALE(1)) dut_u (
		.clk, .reset_n, .fuel_open, .start_stop_phase, .in_band,
		.running_detected, .idle_enabled, .idle_done, .regen_active,
		.auto_mode, .app_type, .manual_operation_mode, .gen_voltage,
		.excitation_voltage, .gen_current, .hv_threshold, .hv_delay,
		.exc_delay, .exc_action, .excitation_signal_function,
		.exc_stop_threshold, .oc_time, .oc_threshold, .sc_threshold,
		.sc_delay, .max_current_action, .op_max_time, .kbd_stop_disable,
		.password, .breaker_external, .di_function, .di_delay, .di_pin,
		.stop_key, .close_cmd, .breaker_closed, .reg_wr_en, .reg_wr_addr,
		.reg_wr_data,
		.overvoltage_shutdown(outs[12]), .alternator_anomaly(outs[11:10]),
		.overcurrent_anomaly(outs[9:8]), .short_circuit_anomaly(outs[7:6]),
		.manual_stop_shutdown(outs[5]), .op_cond_shutdown(outs[4]),
		.close_fail_prealarm(outs[3]), .close_fail_deactivation(outs[2]),
		.contact_short_shutdown(outs[1]),
		.contact_overspeed_shutdown(outs[0]));
	gpm_breaker brk_u (.clk, .reset_n, .close_cmd, .refuse,
		.breaker_closed);

	// ------------------------------------------------------------
	// Clock, cycle count, result watcher and hang guard
	// ------------------------------------------------------------
	always #5 clk = ~clk;
	// Each output change matches the oldest note, never early
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			report("run timed out");
			complete_run();
		end
		if (!reset_n) begin
			prev <= 13'h0000;
		end else if (outs !== prev) begin
			prev <= outs;
			tests_run++;
			if (qv.size() == 0)
				report("unexpected anomaly change");
			else if (outs !== qv[0] || cyc < qt[0])
				report("anomaly value or timing");
			if (qv.size() != 0) begin
				void'(qv.pop_front());
				void'(qt.pop_front());
			end
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task report(input string m);
		$display("[ERR] %0t %s", $time, m);
		failures++;
	endtask
	task note_out(input logic [12:0] m, input int t);
		ev = ev | m;
		qv.push_back(ev);
		qt.push_back(cyc + t);
	endtask
	task settle(input int n);
		hold(n);
		@(negedge clk);
		tests_run++;
		if (qv.size() != 0)
			report("expected anomaly missing");
		qv.delete();
		qt.delete();
		hold(1);
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		reg_wr_en <= 1'b1;
		reg_wr_addr <= a;
		reg_wr_data <= d;
		hold(1);
	endtask
	// Quiet defaults, reset held for 16 cycles
	task rst;
		reset_n <= 1'b0;
		{fuel_open, start_stop_phase, running_detected, idle_enabled} <= 4'h0;
		{idle_done, regen_active, auto_mode, kbd_stop_disable} <= 4'h0;
		{breaker_external, stop_key, close_cmd, refuse} <= 4'h0;
		{reg_wr_en, excitation_signal_function} <= 2'h0;
		{in_band, manual_operation_mode} <= 2'h3;
		{app_type, exc_action, max_current_action} <= 6'h00;
		{gen_voltage, excitation_voltage, gen_current} <= 48'h0;
		{hv_threshold, oc_threshold, sc_threshold} <= 48'hFFFF_FFFF_FFFF;
		{hv_delay, exc_stop_threshold, exc_delay, oc_time} <= 64'h0;
		{sc_delay, op_max_time, reg_wr_addr, reg_wr_data} <= 64'h0;
		{di_function, di_delay, di_pin} <= 84'h0;
		password <= 16'($random(seed));
		ev = 13'h0000;
		hold(16);
		reset_n <= 1'b1;
	endtask
	task complete_run;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 30;
		// Overvoltage: genset, drive type, zero delay
		for (i = 0; i < 3; i++) begin
			rst();
			app_type <= (i == 1) ? `GPM_APP_DRIVE : `GPM_APP_GENSET;
			hv_threshold <= 16'h0100;
			hv_delay <= (i == 2) ? 16'h0000 : 16'h0005;
			gen_voltage <= 16'h0101 + 16'($random(seed) & 255);
			hold(60);
			{fuel_open, start_stop_phase} <= 2'b11;
			hold(60);
			start_stop_phase <= 1'b0;
			if (i == 0)
				note_out(13'h1000, 4 * TC);
			settle(12 * TC);
		end
		// Inverse time then short circuit
		for (i = 1; i < 5; i++) begin
			rst();
			fuel_open <= 1'b1;
			app_type <= (i == 4) ? `GPM_APP_DRIVE : `GPM_APP_GENSET;
			max_current_action <= 2'((i % 3) + 1);
			{oc_threshold, oc_time} <= {16'h0064, 16'h000A};
			{sc_threshold, sc_delay} <= {16'h00C8, 16'h0003};
			gen_current <= 16'h0064;
			hold(40 * TC);
			gen_current <= 16'h0096;
			hold(6 * TC);
			gen_current <= 16'h005A;
			hold(10 * TC);
			gen_current <= 16'h0096;
			if (i < 4)
				note_out(13'((i % 3) + 1) << 8, TC);
			settle(5 * TC);
			gen_current <= 16'h00C9 + 16'($random(seed) & 63);
			if (i < 4)
				note_out(13'((i % 3) + 1) << 6, 2 * TC);
			settle(6 * TC);
		end
		// Charge alternator, each action
		for (i = 0; i < 4; i++) begin
			rst();
			excitation_signal_function <= (i != 0);
			exc_action <= (i == 0) ? 2'h3 : 2'(i);
			{exc_stop_threshold, exc_delay} <= {16'h0200, 16'h0004};
			excitation_voltage <= 16'($random(seed)) & 16'h01FF;
			hold(40);
			fuel_open <= 1'b1;
			if (i != 0)
				note_out(13'(i) << 10, 3 * TC);
			settle(10 * TC);
		end
		// Stop key and remote stop
		for (i = 0; i < 7; i++) begin
			rst();
			{auto_mode, manual_operation_mode} <= (i == 2) ? 2'b01 : 2'b10;
			kbd_stop_disable <= (i == 1);
			hold(4);
			if (i == 0 || i == 3 || i == 6)
				note_out(13'h0020, 0);
			if (i < 2) begin
				stop_key <= 1'b1;
			end else begin
				wr(`GPM_REG_PASSWORD, (i == 4) ? ~password : password);
				if (i >= 5)
					reg_wr_en <= 1'b0; // Idle gap between writes
				hold((i == 5) ? 5002 * TC : ((i == 6) ? 50 : 0));
				wr(`GPM_REG_COMMAND, `GPM_STOP_CODE);
				reg_wr_en <= 1'b0;
			end
			settle(20);
		end
		// Operating conditions not reached
		for (i = 0; i < 6; i++) begin
			rst();
			{auto_mode, manual_operation_mode} <= (i == 1 || i == 2) ?
				2'b01 : 2'b10;
			app_type <= (i == 2) ? `GPM_APP_DRIVE : `GPM_APP_GENSET;
			{fuel_open, in_band} <= {i != 3, i == 4};
			{idle_enabled, op_max_time} <= {i == 5, 16'h0002};
			if (i == 0 || i == 2)
				note_out(13'h0010, TC);
			running_detected <= 1'b1;
			settle(8 * TC);
		end
		// Breaker close failure
		for (i = 0; i < 6; i++) begin
			rst();
			{auto_mode, manual_operation_mode} <= (i == 1 || i == 2) ?
				2'b10 : 2'b01;
			app_type <= (i == 3) ? `GPM_APP_LAMP_MAST : `GPM_APP_GENSET;
			{breaker_external, refuse} <= {i == 4, i != 2};
			di_function <= 16'h0001;
			di_delay <= {48'h0, (i == 5) ? 16'h0000 : 16'h0003};
			for (j = 0; j < 3; j++) begin
				if ((i == 0 && j == 0) || (i == 1 && j == 2))
					note_out((i == 0) ? 13'h0008 : 13'h0004, 2 * TC);
				close_cmd <= 1'b1;
				hold(1);
				close_cmd <= 1'b0;
				hold(6 * TC);
			end
			settle(4);
		end
		// Contacts, interrupted then held
		for (i = 0; i < 5; i++) begin
			rst();
			di_function <= (i == 0) ? 16'h0020 : 16'h0300;
			di_delay <= 64'h0000_0005_0005_0000;
			{regen_active, fuel_open} <= {i == 1, i != 2};
			start_stop_phase <= (i == 4);
			repeat (3) begin
				di_pin <= 4'h6;
				hold(3 * TC);
				di_pin <= 4'h0;
				hold(TC);
			end
			if (i == 0 || i == 3)
				note_out((i == 0) ? 13'h0002 : 13'h0001, 4 * TC);
			di_pin <= 4'h6;
			settle(12 * TC);
		end
		complete_run();
	end
endmodule

bind gpm_monitor gpm_monitor_assertions chk_u (
	.clk, .reset_n, .fuel_open, .start_stop_phase, .auto_mode,
	.kbd_stop_disable, .regen_active, .breaker_external, .app_type,
	.excitation_signal_function, .exc_action, .max_current_action,
	.hv_delay, .password, .reg_wr_en, .reg_wr_addr, .reg_wr_data,
	.overvoltage_shutdown, .alternator_anomaly, .overcurrent_anomaly,
	.short_circuit_anomaly, .manual_stop_shutdown, .op_cond_shutdown,
	.close_fail_deactivation, .contact_overspeed_shutdown);
